//--- design/fan_tach_meter.sv
// Measures the fan tachometer period in reference clock cycles.
// Assumes both the reference clock and the tachometer arrive asynchronously on pins.
module fan_tach_meter #(
    parameter int PERIOD_W = 10
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic refClkIn,
    input wire logic tachIn,
    output logic [PERIOD_W-1:0] period,
    output logic sampleStb,
    output logic stalled
);

    logic [1:0] refSync_q;
    logic [1:0] tachSync_q;
    logic refPrev_q;
    logic tachPrev_q;
    logic [PERIOD_W-1:0] count_q;
    logic refTick;
    logic tachEdge;

    assign refTick = refSync_q[1] & ~refPrev_q;
    assign tachEdge = tachSync_q[1] & ~tachPrev_q;

    // ========================================
    // Input synchronisers.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            refSync_q <= 2'h0;
            tachSync_q <= 2'h0;
            refPrev_q <= 1'b0;
            tachPrev_q <= 1'b0;
        end
        else if (ce)
        begin
            refSync_q <= {refSync_q[0], refClkIn};
            tachSync_q <= {tachSync_q[0], tachIn};
            refPrev_q <= refSync_q[1];
            tachPrev_q <= tachSync_q[1];
        end
    end

    // ========================================
    // Period counter between tachometer rising edges.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= '0;
            period <= '0;
            sampleStb <= 1'b0;
            stalled <= 1'b1;
        end
        else if (ce)
        begin
            sampleStb <= tachEdge;
            if (tachEdge)
            begin
                period <= count_q;
                count_q <= {{(PERIOD_W-1){1'b0}}, refTick};
                stalled <= 1'b0;
            end
            else if (refTick && count_q != {PERIOD_W{1'b1}})
                count_q <= count_q + PERIOD_W'(1);
            else if (count_q == {PERIOD_W{1'b1}})
                stalled <= 1'b1;
        end
    end

endmodule : fan_tach_meter

//--- design/supply_reset_stretch.sv
// Holds the system reset output low while the supply is low and for a hold time after.
// Assumes supplyOk is already synchronised to clk_sys.
`include "tmfs_defs.svh"
module supply_reset_stretch #(
    parameter int HOLD_CYCLES = `RESET_HOLD_MS * `CLK_MHZ * 1000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic supplyOk,
    output logic sysReset_n
);

    logic [31:0] hold_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_q <= 32'h0;
            sysReset_n <= 1'b0;
        end
        else if (ce)
        begin
            if (!supplyOk)
            begin
                hold_q <= 32'h0;
                sysReset_n <= 1'b0;
            end
            else if (hold_q >= 32'(HOLD_CYCLES - 1))
                sysReset_n <= 1'b1;
            else
                hold_q <= hold_q + 32'h1;
        end
    end

endmodule : supply_reset_stretch

//--- design/thermal_monitor_fan_supervisor.sv
// Digital core of a two-channel remote temperature monitor with fan control and supply supervisor.
// Assumes an analog front end delivers temperature codes and diode fault flags on asynchronous pins.
`include "tmfs_defs.svh"
module thermal_monitor_fan_supervisor #(
    parameter int CONV_CYCLES = `CONV_TIME_MS * `CLK_MHZ * 1000,
    parameter int RESET_CYCLES = `RESET_HOLD_MS * `CLK_MHZ * 1000,
    parameter int PERIOD_W = 10
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic [7:0] adcTempOne,
    input wire logic [7:0] adcTempTwo,
    input wire logic diodeOneOpen,
    input wire logic diodeOneShort,
    input wire logic diodeTwoOpen,
    input wire logic diodeTwoShort,
    input wire logic supplyOk,
    input wire logic refClkIn,
    input wire logic fanTachInput,
    output logic [7:0] fanDrive,
    output logic fanFullOn,
    output logic irq,
    output logic sysReset_n
);

    tmfs_pkg::pins_t pinMeta_q;
    tmfs_pkg::pins_t pinSync_q;
    tmfs_pkg::pins_t pinRaw;
    tmfs_pkg::conv_state_t convState_q;
    logic [31:0] convCnt_q;
    logic [7:0] rateLeft_q;
    logic [7:0] tempOne_q;
    logic [7:0] tempTwo_q;
    logic [7:0] config_q;
    logic [7:0] rate_q;
    logic [7:0] limitOne_q;
    logic [7:0] limitTwo_q;
    logic [PERIOD_W-1:0] target_q;
    logic [7:0] intStatus_q;
    logic [7:0] intEnable_q;
    logic [7:0] pointer_q;
    logic [7:0] fanStatus_q;
    logic [PERIOD_W-1:0] period;
    logic sampleStb;
    logic stalled;
    logic stalledPrev_q;
    logic overridePrev_q;
    logic singleShot;
    logic oneShotReq;
    logic convDone;
    logic overTemp;
    logic openFault;
    logic shortFault;
    logic override;
    logic rangeErr;
    logic [PERIOD_W:0] tolerance;
    logic [PERIOD_W:0] upper;
    logic [PERIOD_W:0] lower;
    logic [7:0] intEvents;

    // ========================================
    // Register read decode.
    function automatic logic [7:0] readReg(input logic [7:0] addr);
        logic [15:0] periodWide;
        periodWide = 16'(period);
        unique case (addr)
            `ADDR_TEMP_ONE: readReg = tempOne_q;
            `ADDR_TEMP_TWO: readReg = tempTwo_q;
            `ADDR_CONFIG: readReg = config_q;
            `ADDR_CONV_RATE: readReg = rate_q;
            `ADDR_LIMIT_ONE: readReg = limitOne_q;
            `ADDR_LIMIT_TWO: readReg = limitTwo_q;
            `ADDR_TARGET_LO: readReg = target_q[7:0];
            `ADDR_TARGET_HI: readReg = 8'(target_q >> 8);
            `ADDR_SPEED_LO: readReg = periodWide[7:0];
            `ADDR_SPEED_HI: readReg = periodWide[15:8];
            `ADDR_FAN_STATUS: readReg = fanStatus_q;
            `ADDR_INT_STATUS: readReg = intStatus_q;
            `ADDR_INT_ENABLE: readReg = intEnable_q;
            `ADDR_FAN_DRIVE: readReg = fanDrive;
            default: readReg = 8'h00;
        endcase
    endfunction : readReg

    function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
        hits = (addr == target);
    endfunction : hits

    assign pinRaw = '{one: '{temp: adcTempOne, flags: '{open: diodeOneOpen, shorted: diodeOneShort}},
                      two: '{temp: adcTempTwo, flags: '{open: diodeTwoOpen, shorted: diodeTwoShort}},
                      supplyOk: supplyOk};
    assign singleShot = config_q[`CFG_SINGLE_SHOT];
    assign oneShotReq = regWrStb && hits(regAddr, `ADDR_ONE_SHOT);
    assign convDone = (convState_q == tmfs_pkg::CONV_BUSY) && (convCnt_q >= 32'(CONV_CYCLES - 1));
    assign overTemp = ($signed(tempOne_q) > $signed(limitOne_q)) || ($signed(tempTwo_q) > $signed(limitTwo_q));
    assign openFault = pinSync_q.one.flags.open || pinSync_q.two.flags.open;
    assign shortFault = pinSync_q.one.flags.shorted && pinSync_q.two.flags.shorted;
    assign override = overTemp || openFault || shortFault;
    assign rangeErr = (period > PERIOD_W'(`TACH_MAX_PERIOD)) || (period < PERIOD_W'(`TACH_MIN_PERIOD));
    assign tolerance = (PERIOD_W+1)'(target_q / `SPEED_TOL_DIV);
    assign upper = (PERIOD_W+1)'(target_q) + tolerance;
    assign lower = (PERIOD_W+1)'(target_q) - tolerance;
    assign intEvents = {4'h0, sampleStb & rangeErr, stalled & ~stalledPrev_q,
                        override & ~overridePrev_q, convDone};

    // ========================================
    // Pin synchronisers.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end
        else if (ce)
        begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
        end
    end

    // ========================================
    // Software registers.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            config_q <= `CONFIG_RST;
            rate_q <= `RATE_RST;
            limitOne_q <= `LIMIT_RST;
            limitTwo_q <= `LIMIT_RST;
            target_q <= `TARGET_RST;
            intEnable_q <= 8'h00;
            pointer_q <= 8'h00;
        end
        else if (ce && regWrStb)
        begin
            if (!hits(regAddr, `ADDR_POINTER))
                pointer_q <= regAddr;
            unique case (regAddr)
                `ADDR_CONFIG: config_q <= regWrData;
                `ADDR_CONV_RATE: rate_q <= regWrData;
                `ADDR_LIMIT_ONE: limitOne_q <= regWrData;
                `ADDR_LIMIT_TWO: limitTwo_q <= regWrData;
                `ADDR_TARGET_LO: target_q <= {target_q[PERIOD_W-1:8], regWrData};
                `ADDR_TARGET_HI: target_q <= {regWrData[PERIOD_W-9:0], target_q[7:0]};
                `ADDR_INT_ENABLE: intEnable_q <= regWrData;
                `ADDR_POINTER: pointer_q <= regWrData;
                default: ;
            endcase
        end
    end

    // ========================================
    // Read data, one cycle after the strobe.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            regRdData <= 8'h00;
        else if (ce)
        begin
            if (regRdStb && hits(regAddr, `ADDR_POINTER))
                regRdData <= readReg(pointer_q);
            else if (regRdStb)
                regRdData <= readReg(regAddr);
            else
                regRdData <= 8'h00;
        end
    end

    // ========================================
    // Conversion sequencer.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            convState_q <= tmfs_pkg::CONV_IDLE;
            convCnt_q <= 32'h0;
            rateLeft_q <= 8'h00;
            tempOne_q <= 8'h00;
            tempTwo_q <= 8'h00;
        end
        else if (ce)
        begin
            unique case (convState_q)
                tmfs_pkg::CONV_IDLE:
                begin
                    convCnt_q <= 32'h0;
                    if (!singleShot || oneShotReq)
                        convState_q <= tmfs_pkg::CONV_BUSY;
                end
                tmfs_pkg::CONV_BUSY:
                begin
                    convCnt_q <= convCnt_q + 32'h1;
                    if (convDone)
                    begin
                        tempOne_q <= pinSync_q.one.temp;
                        tempTwo_q <= pinSync_q.two.temp;
                        convCnt_q <= 32'h0;
                        rateLeft_q <= rate_q;
                        convState_q <= singleShot ? tmfs_pkg::CONV_IDLE : tmfs_pkg::CONV_WAIT;
                    end
                end
                tmfs_pkg::CONV_WAIT:
                begin
                    convCnt_q <= convCnt_q + 32'h1;
                    if (singleShot)
                        convState_q <= tmfs_pkg::CONV_IDLE;
                    else if (rateLeft_q == 8'h00)
                    begin
                        convCnt_q <= 32'h0;
                        convState_q <= tmfs_pkg::CONV_BUSY;
                    end
                    else if (convCnt_q >= 32'(CONV_CYCLES - 1))
                    begin
                        convCnt_q <= 32'h0;
                        rateLeft_q <= rateLeft_q - 8'h01;
                    end
                end
            endcase
        end
    end

    // ========================================
    // Fan speed loop and full-on watchdog.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fanDrive <= `DRIVE_FULL;
            fanFullOn <= 1'b0;
            fanStatus_q <= 8'h00;
        end
        else if (ce)
        begin
            fanFullOn <= override;
            fanStatus_q[`STAT_FULL_ON] <= override;
            fanStatus_q[`STAT_STALLED] <= stalled;
            if (override)
                fanDrive <= `DRIVE_FULL;
            else if (target_q == '0)
                fanDrive <= 8'h00;
            else if (stalled)
                fanDrive <= `DRIVE_FULL;
            else if (sampleStb)
            begin
                fanStatus_q[`STAT_RANGE_ERR] <= rangeErr;
                fanStatus_q[`STAT_IN_BAND] <= 1'b0;
                if ((PERIOD_W+1)'(period) > upper)
                begin
                    if (fanDrive != `DRIVE_FULL)
                        fanDrive <= fanDrive + `DRIVE_STEP;
                end
                else if ((PERIOD_W+1)'(period) < lower)
                begin
                    if (fanDrive != 8'h00)
                        fanDrive <= fanDrive - `DRIVE_STEP;
                end
                else
                    fanStatus_q[`STAT_IN_BAND] <= 1'b1;
            end
        end
    end

    // ========================================
    // Interrupt status, set wins over clear.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            intStatus_q <= 8'h00;
            stalledPrev_q <= 1'b1;
            overridePrev_q <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            stalledPrev_q <= stalled;
            overridePrev_q <= override;
            if (regWrStb && hits(regAddr, `ADDR_INT_CLEAR))
                intStatus_q <= (intStatus_q & ~regWrData) | intEvents;
            else
                intStatus_q <= intStatus_q | intEvents;
            irq <= |(intStatus_q & intEnable_q);
        end
    end

    // ========================================
    // Submodules.
    fan_tach_meter #(
        .PERIOD_W(PERIOD_W)
    ) tachMeter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .refClkIn(refClkIn),
        .tachIn(fanTachInput),
        .period(period),
        .sampleStb(sampleStb),
        .stalled(stalled)
    );

    supply_reset_stretch #(
        .HOLD_CYCLES(RESET_CYCLES)
    ) resetStretch (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .supplyOk(pinSync_q.supplyOk),
        .sysReset_n(sysReset_n)
    );

endmodule : thermal_monitor_fan_supervisor

//--- design/tmfs_defs.svh
// Constants for the thermal monitor and fan supervisor: register map, field positions, reset values, timing.
// Assumes the system clock runs at CLK_MHZ and the fan reference clock at REF_CLK_HZ.
`ifndef TMFS_DEFS_SVH
`define TMFS_DEFS_SVH

// ========================================
// Timing
`define CLK_MHZ 250
`define REF_CLK_HZ 32768
`define CONV_TIME_MS 125
`define RESET_HOLD_MS 140
`define TACH_MIN_HZ 100
`define TACH_MAX_HZ 1000
`define TACH_MAX_PERIOD (`REF_CLK_HZ / `TACH_MAX_HZ * 0 + `REF_CLK_HZ / `TACH_MIN_HZ)
`define TACH_MIN_PERIOD (`REF_CLK_HZ / `TACH_MAX_HZ)
`define SPEED_TOL_DIV 50

// ========================================
// Register addresses
`define ADDR_TEMP_ONE 8'h00
`define ADDR_TEMP_TWO 8'h01
`define ADDR_CONFIG 8'h02
`define ADDR_CONV_RATE 8'h03
`define ADDR_ONE_SHOT 8'h04
`define ADDR_LIMIT_ONE 8'h05
`define ADDR_LIMIT_TWO 8'h06
`define ADDR_TARGET_LO 8'h07
`define ADDR_TARGET_HI 8'h08
`define ADDR_SPEED_LO 8'h09
`define ADDR_SPEED_HI 8'h0A
`define ADDR_FAN_STATUS 8'h0B
`define ADDR_INT_STATUS 8'h0C
`define ADDR_INT_CLEAR 8'h0D
`define ADDR_INT_ENABLE 8'h0E
`define ADDR_POINTER 8'h0F
`define ADDR_FAN_DRIVE 8'h10

// ========================================
// Fields and reset values
`define CFG_SINGLE_SHOT 0
`define INT_CONV_DONE 0
`define INT_OVERRIDE 1
`define INT_STALL 2
`define INT_RANGE 3
`define STAT_FULL_ON 0
`define STAT_STALLED 1
`define STAT_IN_BAND 2
`define STAT_RANGE_ERR 3
`define CONFIG_RST 8'h00
`define RATE_RST 8'h02
`define LIMIT_RST 8'h46
`define TARGET_RST 10'h0A4
`define DRIVE_FULL 8'hFF
`define DRIVE_STEP 8'h01

`endif

//--- design/tmfs_pkg.sv
// Types shared by the thermal monitor and fan supervisor.
// Assumes tmfs_defs.svh holds the numeric constants.
package tmfs_pkg;

    typedef enum logic [2:0] {
        CONV_IDLE = 3'b001,
        CONV_BUSY = 3'b010,
        CONV_WAIT = 3'b100
    } conv_state_t;

    typedef struct packed {
        logic open;
        logic shorted;
    } diode_flags_t;

    typedef struct packed {
        logic [7:0] temp;
        diode_flags_t flags;
    } channel_t;

    typedef struct packed {
        channel_t one;
        channel_t two;
        logic supplyOk;
    } pins_t;

endpackage : tmfs_pkg

//--- verification/fan_tach_model.sv
// Fan tachometer and 12.5 MHz reference clock model.
// Assumes the bench sets the tach period in reference ticks; zero stops the fan.
module fan_tach_model (
    input wire logic [9:0] tachTicks,
    output logic refClk,
    output logic tachOut
);
    timeunit 1ns;
    timeprecision 1ps;
    int ticks = 0;

    // ========================================
    // Reference clock and tach pulse train
    initial
    begin
        refClk = 1'b0;
        tachOut = 1'b0;
        forever
        begin
            #40 refClk = ~refClk;
            if (!refClk)
            begin
                ticks = (ticks + 1 >= tachTicks) ? 0 : ticks + 1;
                tachOut = (tachTicks != 10'h000) && (ticks < tachTicks / 2);
            end
        end
    end
endmodule : fan_tach_model

//--- verification/thermal_monitor_fan_supervisor_asserts.sv
// Concurrent checks on the thermal monitor and fan supervisor ports.
// Assumes one clock domain and hold counts handed on by bind.
`include "tmfs_defs.svh"
module thermal_monitor_fan_supervisor_asserts #(
    parameter int CONV_CYCLES = 200,
    parameter int RESET_CYCLES = 100
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic diodeOneOpen,
    input wire logic diodeTwoOpen,
    input wire logic diodeOneShort,
    input wire logic diodeTwoShort,
    input wire logic supplyOk,
    input wire logic [7:0] fanDrive,
    input wire logic fanFullOn,
    input wire logic irq,
    input wire logic sysReset_n
);
    logic [31:0] okCount_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ========================================
    // Cycles with the supply good
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            okCount_q <= 32'h0000_0000;
        else if (!supplyOk)
            okCount_q <= 32'h0000_0000;
        else if (okCount_q != 32'hFFFF_FFFF)
            okCount_q <= okCount_q + 32'h0000_0001;
    end

    // ========================================
    // Properties
    property p_rd_idle;
        !$past(regRdStb) |-> regRdData == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_unmapped;
        regRdStb && regAddr == 8'hFF |=> regRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_irq_off;
        regWrStb && regAddr == `ADDR_INT_ENABLE && regWrData == 8'h00 |-> ##2 !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with enables cleared");
    property p_open;
        (diodeOneOpen || diodeTwoOpen) [*4] |=> fanFullOn && fanDrive == `DRIVE_FULL;
    endproperty
    a_open: assert property (p_open) else $error("open diode without full fan");
    property p_short;
        (diodeOneShort && diodeTwoShort) [*4] |=> fanFullOn;
    endproperty
    a_short: assert property (p_short) else $error("double short without full fan");
    property p_full_drive;
        fanFullOn |-> ##[0:1] fanDrive == `DRIVE_FULL;
    endproperty
    a_full_drive: assert property (p_full_drive) else $error("override without full drive");
    property p_step;
        $changed(fanDrive) && fanDrive != 8'h00 && fanDrive != 8'hFF
            |-> fanDrive == $past(fanDrive) + 8'h01 || fanDrive == $past(fanDrive) - 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("drive moved by more than one");
    property p_supply_low;
        !supplyOk [*3] |=> !sysReset_n;
    endproperty
    a_supply_low: assert property (p_supply_low) else $error("reset out high on low supply");
    property p_hold;
        $rose(sysReset_n) |-> okCount_q >= RESET_CYCLES;
    endproperty
    a_hold: assert property (p_hold) else $error("reset out released early");
    property p_release;
        okCount_q == RESET_CYCLES + 8 |-> sysReset_n;
    endproperty
    a_release: assert property (p_release) else $error("reset out not released");
    c_full: cover property ($rose(fanFullOn));
    c_irq: cover property ($rose(irq));
    c_rst: cover property ($rose(sysReset_n));
endmodule : thermal_monitor_fan_supervisor_asserts

//--- verification/thermal_monitor_fan_supervisor_tb.sv
// Self-checking bench for the thermal monitor and fan supervisor.
// Assumes the defines, package, design, checker and fan model are compiled first.
`include "tmfs_defs.svh"
`define CHK(nm, ex, got) \
    begin \
        numChecks++; \
        if ((got) !== (ex)) \
        begin \
            errCount++; \
            $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
        end \
    end
`define WAITC(c, lim) \
    begin \
        n = 0; \
        while ((c) !== 1'b1 && n < (lim)) \
        begin \
            @(negedge clk_sys); \
            n++; \
        end \
        `CHK("wait", 1'b1, n < (lim)) \
        if (n >= (lim)) \
            reportAndStop(); \
    end
bind thermal_monitor_fan_supervisor thermal_monitor_fan_supervisor_asserts #(
    .CONV_CYCLES(CONV_CYCLES), .RESET_CYCLES(RESET_CYCLES)
) chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .diodeOneOpen(diodeOneOpen), .diodeTwoOpen(diodeTwoOpen),
    .diodeOneShort(diodeOneShort), .diodeTwoShort(diodeTwoShort), .supplyOk(supplyOk),
    .fanDrive(fanDrive), .fanFullOn(fanFullOn), .irq(irq), .sysReset_n(sysReset_n)
);
module thermal_monitor_fan_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 200;
    localparam int HOLD = 100;
    logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, supplyOk = 1'b1;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, fanDrive, drv;
    logic regWrStb = 1'b0, regRdStb = 1'b0, fanFullOn, irq, sysReset_n, refClkIn, fanTachInput;
    logic [7:0] adcTempOne = 8'h05, adcTempTwo = 8'h19;
    logic [3:0] diodes = 4'h0;
    logic [9:0] tachTicks = 10'h028;
    logic [3:0] pats [4] = '{4'h8, 4'h4, 4'h2, 4'h3};
    logic [3:0] expOn = 4'hB;
    int n;
    int errCount = 0;
    int numChecks = 0;

    thermal_monitor_fan_supervisor #(.CONV_CYCLES(CONV), .RESET_CYCLES(HOLD), .PERIOD_W(10)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .adcTempOne(adcTempOne),
        .adcTempTwo(adcTempTwo), .diodeOneOpen(diodes[3]), .diodeOneShort(diodes[1]),
        .diodeTwoOpen(diodes[2]), .diodeTwoShort(diodes[0]), .supplyOk(supplyOk), .refClkIn(refClkIn),
        .fanTachInput(fanTachInput), .fanDrive(fanDrive), .fanFullOn(fanFullOn), .irq(irq),
        .sysReset_n(sysReset_n)
    );
    fan_tach_model fan (.tachTicks(tachTicks), .refClk(refClkIn), .tachOut(fanTachInput));
    always #2 clk_sys = ~clk_sys;

    // ========================================
    // Register access tasks
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk_sys);
        regWrStb <= 1'b0;
    endtask : wrReg

    task automatic rdChk(input logic [7:0] a, input logic [7:0] ex, input string nm);
        @(posedge clk_sys);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        @(negedge clk_sys);
        `CHK(nm, ex, regRdData)
    endtask : rdChk

    task automatic reportAndStop();
        $display("checks %0d errors %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : reportAndStop

    // ========================================
    // Test sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        `CHK("reset out", 1'b0, sysReset_n)
        rdChk(`ADDR_CONFIG, `CONFIG_RST, "config");
        rdChk(`ADDR_CONV_RATE, `RATE_RST, "rate");
        rdChk(`ADDR_LIMIT_TWO, `LIMIT_RST, "limit");
        rdChk(8'hFF, 8'h00, "unmapped");
        wrReg(`ADDR_INT_ENABLE, 8'h01);
        wrReg(`ADDR_TARGET_LO, 8'h3C);
        rdChk(`ADDR_TARGET_LO, 8'h3C, "target");
        `WAITC(irq, 4 * CONV)
        wrReg(`ADDR_INT_CLEAR, 8'h01);
        repeat (2) @(negedge clk_sys);
        `WAITC(irq, 4 * CONV)
        `CHK("auto spacing", 1'b1, n > 3 * CONV - 12 && n < 3 * CONV + 8)
        wrReg(`ADDR_CONFIG, 8'h01);
        repeat (4 * CONV) @(posedge clk_sys);
        wrReg(`ADDR_INT_CLEAR, 8'h01);
        adcTempOne <= 8'hE7;
        wrReg(`ADDR_ONE_SHOT, 8'h00);
        `WAITC(irq, CONV + 20)
        `CHK("conv time", 1'b1, n > CONV - 3 && n < CONV + 6)
        rdChk(`ADDR_TEMP_ONE, 8'hE7, "temp one");
        wrReg(`ADDR_POINTER, `ADDR_TEMP_TWO);
        rdChk(`ADDR_POINTER, 8'h19, "receive byte");
        wrReg(`ADDR_INT_CLEAR, 8'h01);
        repeat (2) @(negedge clk_sys);
        `CHK("irq clear", 1'b0, irq)
        drv = fanDrive;
        `WAITC(fanDrive !== drv, 2000)
        `CHK("drive step", drv - 8'h01, fanDrive)
        rdChk(`ADDR_SPEED_LO, 8'h28, "speed");
        wrReg(`ADDR_TARGET_LO, 8'h28);
        repeat (1700) @(posedge clk_sys);
        rdChk(`ADDR_FAN_STATUS, 8'h04, "in band");
        tachTicks <= 10'h014;
        repeat (1700) @(posedge clk_sys);
        rdChk(`ADDR_FAN_STATUS, 8'h08, "out of range");
        tachTicks <= 10'h028;
        wrReg(`ADDR_LIMIT_ONE, 8'hE0);
        wrReg(`ADDR_ONE_SHOT, 8'h00);
        `WAITC(fanFullOn, CONV + 20)
        `CHK("full drive", `DRIVE_FULL, fanDrive)
        wrReg(`ADDR_LIMIT_ONE, 8'h10);
        wrReg(`ADDR_ONE_SHOT, 8'h00);
        `WAITC(!fanFullOn, CONV + 20)
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            diodes <= pats[i];
            repeat (6) @(negedge clk_sys);
            `CHK("full on", expOn[i], fanFullOn)
            @(posedge clk_sys);
            diodes <= 4'h0;
            repeat (6) @(negedge clk_sys);
        end
        @(posedge clk_sys);
        supplyOk <= 1'b0;
        repeat (6) @(negedge clk_sys);
        `CHK("reset low", 1'b0, sysReset_n)
        @(posedge clk_sys);
        supplyOk <= 1'b1;
        repeat (HOLD - 2) @(negedge clk_sys);
        `CHK("reset held", 1'b0, sysReset_n)
        `WAITC(sysReset_n, 20)
        `WAITC(irq, CONV)
        wrReg(`ADDR_INT_ENABLE, 8'h00);
        repeat (2) @(negedge clk_sys);
        `CHK("irq off", 1'b0, irq)
        tachTicks <= 10'h000;
        repeat (100) @(posedge clk_sys);
        wrReg(`ADDR_INT_CLEAR, 8'hFF);
        wrReg(`ADDR_INT_ENABLE, 8'h04);
        `WAITC(irq, 21000)
        `CHK("stall drive", `DRIVE_FULL, fanDrive)
        rdChk(`ADDR_INT_STATUS, 8'h04, "stall event");
        reportAndStop();
    end
endmodule : thermal_monitor_fan_supervisor_tb
